// *** word_load_pkg.sv ***
// Shared constants and types for the word load unit
package word_load_pkg;
    localparam int XLEN = 64;
    localparam int WORD_W = 32;
    localparam int OFS16_W = 16;
    localparam int OFS9_W = 9;
    localparam int OFS11_W = 11;
    localparam logic [1:0] ALIGN_MASK = 2'h3;
    localparam int SIGN_BIT = 31;
    localparam logic [7:0] EXC_NONE = 8'h00;

    // Load kinds, one-hot
    typedef enum logic [4:0] {
        OP_INT = 5'b0_0001,
        OP_FLOAT = 5'b0_0010,
        OP_SECOND_COPROCESSOR = 5'b0_0100,
        OP_KUSER = 5'b0_1000,
        OP_LEFT = 5'b1_0000
    } load_op_type;

    // Pipeline states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XLATE = 3'b010,
        ST_MEM = 3'b100
    } load_state_type;

    // Segment access modes as seen by translation
    typedef enum logic [1:0] {
        SEG_KERNEL = 2'h0,
        SEG_MAPPED_USER_KERNEL = 2'h1,
        SEG_UNMAPPED_USER = 2'h2,
        SEG_MAPPED_USER = 2'h3
    } seg_mode_type;

    // Decoded load request
    typedef struct packed {
        load_op_type op;
        logic [4:0] rt;
        logic [15:0] offset;
        logic [63:0] base;
        logic [63:0] rt_old;
    } load_req_type;

    // Exception flags
    typedef struct packed {
        logic tlb_refill;
        logic tlb_invalid;
        logic bus_error;
        logic addr_error;
        logic reserved_instr;
        logic cop_unusable;
        logic watch;
        logic none;
    } load_exc_type;

    // Result written back
    typedef struct packed {
        logic int_we;
        logic float_we;
        logic second_coprocessor_we;
        logic [4:0] rt;
        logic [63:0] data;
    } load_result_type;
endpackage

// *** word_load_unit.sv ***
// Word load execution unit: address, checks, lane select, merge, write back
// Operation
// [R01] Integer load address is base plus sign-extended 16-bit offset.
// [R02] Kernel user-space load sign-extends fetched word into integer register.
// [R03] Kernel user-space load address uses sign-extended 9-bit offset.
// [R04] Kernel user-space load translates mapped-user-kernel segments with user mapping.
// [R05] Kernel user-space load may also reach the other two user segment modes.
// [R06] Kernel user-space load exists only when enhanced virtual addressing is set.
// [R07] Kernel user-space load needs system coprocessor access, else exception.
// [R08] Before release 6, nonzero low address bits raise address error.
// [R09] Release 6 may accept misaligned word loads in hardware.
// [R10] Float load writes low word; upper half is undefined.
// [R11] Float load address is base plus sign-extended 16-bit offset.
// [R12] Float and coprocessor loads report translation, address, decode, unusable, watch.
// [R13] Integer load reports translation, bus, address and watch exceptions.
// [R14] Coprocessor two load writes sign-extended word to named register.
// [R15] Coprocessor two offset is 11 bits in release 6, else 16.
// [R16] Left merge loads top 1 to 4 bytes, keeps the rest.
// [R17] Left merge targets low word, replicates bit 31 upward.
// [R18] Left merge byte choice uses low address bits and endianness.
// [R19] Release 6 builds no left merge; misaligned loads are supported.
// [R20] Lane picked by address bit 2 and endian controls, byte index times eight.
module word_load_unit #(
    parameter bit RELEASE6 = 1'b0,
    parameter bit MISALIGN_OK = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire word_load_pkg::load_req_type req,
    output logic req_ready,
    input wire logic enhanced_virt_addr_enable,
    input wire logic system_coprocessor_usable,
    input wire logic float_usable,
    input wire logic second_coprocessor_usable,
    input wire logic user_endian_swap,
    input wire logic cpu_big_endian_flag,
    output logic xlate_valid,
    output logic [63:0] effective_address,
    output logic xlate_user_mapping,
    input wire logic xlate_done,
    input wire word_load_pkg::seg_mode_type xlate_seg_mode,
    input wire logic xlate_tlb_refill,
    input wire logic xlate_tlb_invalid,
    input wire logic xlate_watch,
    output logic mem_valid,
    output logic [2:0] mem_byte_swizzle,
    input wire logic mem_done,
    input wire logic [63:0] mem_doubleword,
    input wire logic mem_bus_error,
    output logic done,
    output word_load_pkg::load_result_type result,
    output word_load_pkg::load_exc_type exc
);
    import word_load_pkg::*;

    // Refuse parameter sets the logic cannot serve, at elaboration
    if (XLEN != 64) begin : g_xlen_chk
        $error("word_load_unit serves 64-bit registers only");
    end
    if (RELEASE6 && !MISALIGN_OK) begin : g_misalign_chk
        $error("release 6 needs misaligned support");
    end

    load_state_type state_r, state_nxt;
    load_req_type req_r;
    logic [63:0] addr_r;
    logic [63:0] addr_nxt;
    load_exc_type exc_nxt;
    logic decode_fault;
    logic [2:0] byte_idx;
    logic [31:0] word_val;
    logic [31:0] left_val;

    // Sign-extend an offset of the given width held in the low bits
    function automatic logic [63:0] sext_ofs(input logic [15:0] ofs, input int width);
        logic [63:0] v;
        v = {{48{ofs[15]}}, ofs};
        if (width == OFS9_W) v = {{55{ofs[8]}}, ofs[8:0]};
        else if (width == OFS11_W) v = {{53{ofs[10]}}, ofs[10:0]};
        return v;
    endfunction

    // Effective address per load kind
    always_comb begin
        unique case (req.op)
            OP_KUSER: addr_nxt = req.base + sext_ofs(req.offset, OFS9_W); // [R03]
            OP_SECOND_COPROCESSOR: addr_nxt = req.base + sext_ofs(req.offset,
                                    RELEASE6 ? OFS11_W : OFS16_W); // [R15]
            OP_FLOAT: addr_nxt = req.base + sext_ofs(req.offset, OFS16_W); // [R11]
            default: addr_nxt = req.base + sext_ofs(req.offset, OFS16_W); // [R01]
        endcase
    end

    // Decode faults caught before any translation
    always_comb begin
        decode_fault = 1'b0;
        if (req.op == OP_KUSER) begin
            decode_fault = !enhanced_virt_addr_enable || !system_coprocessor_usable; // [R06] [R07]
        end
        if (req.op == OP_LEFT && RELEASE6) decode_fault = 1'b1; // [R19]
        if (req.op == OP_FLOAT && !float_usable) decode_fault = 1'b1; // [R12]
        if (req.op == OP_SECOND_COPROCESSOR && !second_coprocessor_usable) decode_fault = 1'b1; // [R12]
    end

    assign req_ready = (state_r == ST_IDLE);

    // State sequencing; no timeouts since partners always answer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (req_valid) state_nxt = decode_fault ? ST_IDLE : ST_XLATE;
            ST_XLATE: begin
                if (xlate_done) begin
                    state_nxt = ST_MEM;
                    if (xlate_tlb_refill || xlate_tlb_invalid || exc_nxt.addr_error ||
                        exc_nxt.watch || exc_nxt.reserved_instr) state_nxt = ST_IDLE;
                end
            end
            ST_MEM: if (mem_done) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) state_r <= ST_IDLE;
        else state_r <= state_nxt;
    end

    // Capture the request and its address
    always_ff @(posedge clk) begin
        if (rst) begin
            req_r <= '0;
            addr_r <= 64'h0000_0000_0000_0000;
        end else if (req_valid && req_ready) begin
            req_r <= req;
            addr_r <= addr_nxt;
        end
    end

    // Translation request; user mapping only for the kernel user-space load
    assign xlate_valid = (state_r == ST_XLATE);
    assign effective_address = addr_r;
    assign xlate_user_mapping = (req_r.op == OP_KUSER); // [R04]
    assign mem_valid = (state_r == ST_MEM);
    // Physical low bits swapped under reverse endian, word lane only
    assign mem_byte_swizzle = {user_endian_swap, 2'b00}; // [R20]

    // Exception collection for decode, translation and memory phases
    always_comb begin
        exc_nxt = '0;
        if (state_r == ST_IDLE) begin
            // Missing address mode only matters to the kernel user-space load
            exc_nxt.reserved_instr = decode_fault && (req.op == OP_LEFT ||
                (req.op == OP_KUSER && !enhanced_virt_addr_enable)); // [R06] [R19]
            exc_nxt.cop_unusable = decode_fault && !exc_nxt.reserved_instr; // [R07]
        end else if (state_r == ST_XLATE) begin
            exc_nxt.tlb_refill = xlate_tlb_refill; // [R12] [R13]
            exc_nxt.tlb_invalid = xlate_tlb_invalid;
            exc_nxt.watch = xlate_watch;
            // Left merge handles any alignment; others trap before release 6
            exc_nxt.addr_error = (req_r.op != OP_LEFT) &&
                (addr_r[1:0] & ALIGN_MASK) != 2'b00 && !(RELEASE6 && MISALIGN_OK); // [R08] [R09]
            if (req_r.op == OP_KUSER) begin
                exc_nxt.addr_error = exc_nxt.addr_error ||
                    !(xlate_seg_mode inside {SEG_MAPPED_USER_KERNEL, SEG_UNMAPPED_USER,
                                             SEG_MAPPED_USER}); // [R05]
            end
        end else begin
            // Bus error only on kinds that can report it
            exc_nxt.bus_error = mem_bus_error &&
                !(req_r.op inside {OP_FLOAT, OP_SECOND_COPROCESSOR}); // [R13]
        end
        exc_nxt.none = !(exc_nxt.tlb_refill || exc_nxt.tlb_invalid || exc_nxt.bus_error ||
                         exc_nxt.addr_error || exc_nxt.reserved_instr ||
                         exc_nxt.cop_unusable || exc_nxt.watch);
    end

    // Lane and byte selection
    always_comb begin
        byte_idx = {addr_r[2] ^ cpu_big_endian_flag, addr_r[1:0]}; // [R20]
        word_val = mem_doubleword[8 * byte_idx +: 32];
    end

    // Left merge: memory bytes at top, old register bytes kept below
    function automatic logic [31:0] merge_left(input logic [63:0] dw, input logic [1:0] lo,
                                               input logic big, input logic [2:0] a,
                                               input logic [31:0] old);
        logic [1:0] b;
        logic [31:0] mw;
        logic [31:0] t;
        b = lo ^ {2{big}};
        mw = (a[2] ^ big) ? dw[63:32] : dw[31:0];
        unique case (b)
            2'h0: t = {mw[7:0], old[23:0]};
            2'h1: t = {mw[15:0], old[15:0]};
            2'h2: t = {mw[23:0], old[7:0]};
            default: t = mw;
        endcase
        return t;
    endfunction

    assign left_val = merge_left(mem_doubleword, addr_r[1:0], cpu_big_endian_flag,
                                 addr_r[2:0], req_r.rt_old[31:0]); // [R16] [R18]

    // Registered result and exception report
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
            result <= '0;
            exc <= '0;
        end else begin
            done <= 1'b0;
            result.int_we <= 1'b0;
            result.float_we <= 1'b0;
            result.second_coprocessor_we <= 1'b0;
            if ((state_r == ST_IDLE && req_valid && decode_fault) ||
                (state_r == ST_XLATE && xlate_done && state_nxt == ST_IDLE) ||
                (state_r == ST_MEM && mem_done)) begin
                done <= 1'b1;
                exc <= exc_nxt;
                result.rt <= (state_r == ST_IDLE) ? req.rt : req_r.rt;
                if (state_r == ST_MEM && !exc_nxt.bus_error) begin
                    unique case (req_r.op)
                        OP_FLOAT: begin
                            // Upper half left as zero; software may not rely on it
                            result.data <= {32'h0000_0000, word_val}; // [R10]
                            result.float_we <= 1'b1;
                        end
                        OP_SECOND_COPROCESSOR: begin
                            result.data <= {{32{word_val[SIGN_BIT]}}, word_val}; // [R14]
                            result.second_coprocessor_we <= 1'b1;
                        end
                        OP_LEFT: begin
                            result.data <= {{32{left_val[SIGN_BIT]}}, left_val}; // [R17]
                            result.int_we <= 1'b1;
                        end
                        default: begin
                            result.data <= {{32{word_val[SIGN_BIT]}}, word_val}; // [R02]
                            result.int_we <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // Assertions
    property p_kuser_gate;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && req.op == OP_KUSER && !enhanced_virt_addr_enable)
            |=> done && exc.reserved_instr;
    endproperty
    a_kuser_gate: assert property (p_kuser_gate) else $error("gated load not refused"); // [R06]

    property p_cop0_gate;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && req.op == OP_KUSER && enhanced_virt_addr_enable &&
         !system_coprocessor_usable) |=> done && exc.cop_unusable;
    endproperty
    a_cop0_gate: assert property (p_cop0_gate) else $error("no unusable trap"); // [R07]

    property p_int_addr;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && req.op == OP_INT) |=>
            effective_address == $past(req.base) + {{48{$past(req.offset[15])}},
                                                    $past(req.offset)};
    endproperty
    a_int_addr: assert property (p_int_addr) else $error("bad integer address"); // [R01]

    property p_kuser_addr;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && req.op == OP_KUSER) |=>
            effective_address == $past(req.base) + {{55{$past(req.offset[8])}},
                                                    $past(req.offset[8:0])};
    endproperty
    a_kuser_addr: assert property (p_kuser_addr) else $error("bad 9-bit address"); // [R03]

    property p_user_map;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && !decode_fault) |=>
            xlate_valid && (xlate_user_mapping == ($past(req.op) == OP_KUSER));
    endproperty
    a_user_map: assert property (p_user_map) else $error("wrong mapping select"); // [R04]

    property p_align;
        @(posedge clk) disable iff (rst)
        (xlate_valid && xlate_done && !RELEASE6 && req_r.op == OP_INT &&
         effective_address[1:0] != 2'b00) |=> done && exc.addr_error;
    endproperty
    a_align: assert property (p_align) else $error("misaligned load not trapped"); // [R08]

    property p_sign;
        @(posedge clk) disable iff (rst)
        (done && (result.int_we || result.second_coprocessor_we)) |->
            result.data[63:32] == {32{result.data[31]}};
    endproperty
    a_sign: assert property (p_sign) else $error("upper half not sign copy"); // [R02]

    property p_no_left_r6;
        @(posedge clk) disable iff (rst)
        (req_valid && req_ready && req.op == OP_LEFT) |=>
            (RELEASE6 ? (done && exc.reserved_instr && !result.int_we) : xlate_valid);
    endproperty
    a_no_left_r6: assert property (p_no_left_r6) else $error("left merge handling wrong"); // [R19]

    c_int_load: cover property (@(posedge clk) disable iff (rst) done && result.int_we);
    c_float_load: cover property (@(posedge clk) disable iff (rst) done && result.float_we);
    c_second_coprocessor_load: cover property (@(posedge clk) disable iff (rst) done && result.second_coprocessor_we);
    c_addr_err: cover property (@(posedge clk) disable iff (rst) done && exc.addr_error);
endmodule

// *** word_load_partner.sv ***
// Behavioural translation stage and memory return path facing the load unit
module word_load_partner #(
    parameter logic [63:0] MEM_PATTERN = 64'h8123_4567_70E1_D2C3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic xlate_valid,
    input wire logic mem_valid,
    input wire logic [2:0] mem_byte_swizzle,
    input wire word_load_pkg::seg_mode_type cfg_seg,
    input wire logic [3:0] cfg_flt,
    input wire logic [1:0] cfg_dly,
    output logic xlate_done,
    output word_load_pkg::seg_mode_type xlate_seg_mode,
    output logic xlate_tlb_refill,
    output logic xlate_tlb_invalid,
    output logic xlate_watch,
    output logic mem_done,
    output logic [63:0] mem_doubleword,
    output logic mem_bus_error
);
    import word_load_pkg::*;
    logic [1:0] cnt_r;
    logic [63:0] line;

    // Answer on falling edges so the unit samples settled values
    always @(negedge clk) begin
        xlate_done <= 1'b0;
        mem_done <= 1'b0;
        if (rst) begin
            cnt_r <= 2'h0;
        end else if ((xlate_valid && !xlate_done) || (mem_valid && !mem_done)) begin
            if (cnt_r == cfg_dly) begin
                cnt_r <= 2'h0;
                xlate_done <= xlate_valid;
                mem_done <= !xlate_valid;
            end else begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end

    // Reverse endian moves a word fetch into the other half
    assign line = mem_byte_swizzle[2] ? {MEM_PATTERN[31:0], MEM_PATTERN[63:32]} : MEM_PATTERN;
    // Outside a pulse the lines carry the inverse, never a stale copy
    assign mem_doubleword = mem_done ? line : ~line;
    assign mem_bus_error = mem_done ? cfg_flt[0] : !cfg_flt[0];
    assign xlate_watch = xlate_done ? cfg_flt[1] : !cfg_flt[1];
    assign xlate_tlb_invalid = xlate_done ? cfg_flt[2] : !cfg_flt[2];
    assign xlate_tlb_refill = xlate_done ? cfg_flt[3] : !cfg_flt[3];
    assign xlate_seg_mode = xlate_done ? cfg_seg : seg_mode_type'(~cfg_seg);
endmodule

// *** tb_word_load_unit.sv ***
// Self-checking bench for the word load unit
module tb_word_load_unit;
    timeunit 1ns;
    timeprecision 1ns;
    import word_load_pkg::*;
    localparam logic [63:0] PAT = 64'h8123_4567_70E1_D2C3;
    localparam logic [63:0] OLD = 64'hAAAA_AAAA_5566_7788;
    logic clk = 1'b0;
    logic rst, req_valid, req_ready, eva, sys_ok, fp_ok, c2_ok, swap, big, um_seen;
    logic xv, um, xd, xref, xinv, xwat, mv, md, mbus, done;
    logic [63:0] ea, mdw, ea_seen;
    logic [31:0] w;
    logic [1:0] bsel, p_dly;
    logic [2:0] swz;
    logic [3:0] p_flt;
    load_req_type req;
    seg_mode_type xseg, p_seg;
    load_result_type result, res_seen;
    load_exc_type exc, exc_seen;
    load_op_type ops [4] = '{OP_INT, OP_FLOAT, OP_SECOND_COPROCESSOR, OP_KUSER};
    logic [7:0] codes [4] = '{8'h20, 8'h02, 8'h40, 8'h80};
    int fail_count = 0;
    int checks = 0;

    word_load_unit dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .enhanced_virt_addr_enable(eva),
        .system_coprocessor_usable(sys_ok), .float_usable(fp_ok), .second_coprocessor_usable(c2_ok),
        .user_endian_swap(swap), .cpu_big_endian_flag(big), .xlate_valid(xv),
        .effective_address(ea), .xlate_user_mapping(um), .xlate_done(xd),
        .xlate_seg_mode(xseg), .xlate_tlb_refill(xref), .xlate_tlb_invalid(xinv),
        .xlate_watch(xwat), .mem_valid(mv), .mem_byte_swizzle(swz), .mem_done(md),
        .mem_doubleword(mdw), .mem_bus_error(mbus), .done(done), .result(result), .exc(exc));
    word_load_partner #(.MEM_PATTERN(PAT)) partner_u (.clk(clk), .rst(rst), .xlate_valid(xv),
        .mem_valid(mv), .mem_byte_swizzle(swz), .cfg_seg(p_seg), .cfg_flt(p_flt),
        .cfg_dly(p_dly), .xlate_done(xd), .xlate_seg_mode(xseg), .xlate_tlb_refill(xref),
        .xlate_tlb_invalid(xinv), .xlate_watch(xwat), .mem_done(md), .mem_doubleword(mdw),
        .mem_bus_error(mbus));

    always #50 clk = ~clk;

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One load, driven on falling edges, bounded wait for the done pulse
    task automatic run(input load_op_type op, input logic [15:0] ofs, input logic [63:0] base);
        int n;
        n = 0;
        ea_seen = '1;
        um_seen = 1'b0;
        @(negedge clk);
        req = '{op, 5'h07, ofs, base, OLD};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 40) begin
            if (xv === 1'b1) begin
                ea_seen = ea;
                um_seen = um;
            end
            @(negedge clk);
            n++;
        end
        chk(done, 1'b1);
        res_seen = result;
        exc_seen = exc;
    endtask

    task automatic expect_ok(input logic [2:0] we, input logic [63:0] data);
        chk(exc_seen, 8'h01);
        chk({res_seen.int_we, res_seen.float_we, res_seen.second_coprocessor_we}, we);
        chk(res_seen.rt, 5'h07);
        chk(res_seen.data, data);
    endtask

    task automatic expect_exc(input logic [7:0] code);
        chk(exc_seen, code);
        chk({res_seen.int_we, res_seen.float_we, res_seen.second_coprocessor_we}, 3'h0);
    endtask

    // Word as the unit should pick it; swap is modelled in the memory
    function automatic logic [31:0] wd(input logic a2, input logic b);
        logic [63:0] d;
        d = swap ? {PAT[31:0], PAT[63:32]} : PAT;
        return d[32*(a2^b) +: 32];
    endfunction

    function automatic logic [63:0] sx(input logic [31:0] v);
        return {{32{v[31]}}, v};
    endfunction

    // Watchdog, far beyond the 150 or so cycles the tests take
    initial begin
        #1_000_000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        {rst, eva, sys_ok, fp_ok, c2_ok} = 5'h1F;
        {req_valid, swap, big, p_flt, p_dly} = '0;
        req = '0;
        p_seg = SEG_MAPPED_USER_KERNEL;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk({req_ready, done, exc}, 10'h200);
        // Both byte orders, swap, both halves; slow partner on odd passes
        for (int i = 0; i < 8; i++) begin
            swap = i[2];
            big = i[1];
            p_dly = i[0] ? 2'h2 : 2'h0;
            run(OP_INT, 16'hFFF8, 64'h1008 + 64'(i[0]) * 4);
            chk(ea_seen, 64'h1000 + 64'(i[0]) * 4);
            expect_ok(3'h4, sx(wd(i[0], big)));
            chk(um_seen, 1'b0);
        end
        $display("test lanes done");
        {swap, big, p_dly} = '0;
        for (int j = 0; j < 4; j++) begin
            p_flt = 4'h1 << j;
            run(OP_INT, 16'h0000, 64'h1000);
            expect_exc(codes[j]);
        end
        p_flt = 4'h0;
        for (int j = 0; j < 4; j++) begin
            run(ops[j], 16'h0000, 64'h1002);
            expect_exc(8'h10);
        end
        $display("test faults done");
        for (int s = 1; s < 4; s++) begin
            p_seg = seg_mode_type'(s);
            run(OP_KUSER, 16'hFE10, 64'h2000);
            chk(ea_seen, 64'h2010);
            chk(um_seen, 1'b1);
            expect_ok(3'h4, sx(wd(1'b0, big)));
        end
        p_seg = SEG_KERNEL;
        run(OP_KUSER, 16'h0000, 64'h2000);
        expect_exc(8'h10);
        p_seg = SEG_MAPPED_USER;
        eva = 1'b0;
        run(OP_KUSER, 16'h0000, 64'h2000);
        expect_exc(8'h08);
        eva = 1'b1;
        sys_ok = 1'b0;
        run(OP_KUSER, 16'h0000, 64'h2000);
        expect_exc(8'h04);
        sys_ok = 1'b1;
        $display("test kernel user load done");
        run(OP_FLOAT, 16'h8000, 64'h1_0004);
        chk(ea_seen, 64'h8004);
        expect_ok(3'h2, {32'h0, wd(1'b1, big)});
        fp_ok = 1'b0;
        run(OP_FLOAT, 16'h0000, 64'h1000);
        expect_exc(8'h04);
        fp_ok = 1'b1;
        p_flt = 4'h8;
        run(OP_FLOAT, 16'h0000, 64'h1000);
        expect_exc(8'h80);
        p_flt = 4'h0;
        run(OP_SECOND_COPROCESSOR, 16'h8010, 64'h1_0000);
        chk(ea_seen, 64'h8010);
        expect_ok(3'h1, sx(wd(1'b0, big)));
        c2_ok = 1'b0;
        run(OP_SECOND_COPROCESSOR, 16'h0000, 64'h1000);
        expect_exc(8'h04);
        c2_ok = 1'b1;
        $display("test coprocessor loads done");
        // Every byte offset in both byte orders
        for (int k = 0; k < 8; k++) begin
            big = k[2];
            bsel = k[1:0] ^ {big, big};
            w = wd(1'b0, big);
            w = (w << 8 * (3 - bsel)) | (OLD[31:0] & (32'hFFFF_FFFF >> 8 * (bsel + 1)));
            run(OP_LEFT, 16'h0000, 64'h3000 + 64'(k[1:0]));
            expect_ok(3'h4, sx(w));
        end
        $display("test left merge done");
        final_report();
    end
endmodule
